/* include/card_pad_pkg.sv */
// Constants, types and register map for the card pad mode and line control block
// Operation
// - Data lines one to three input after power-up
// - Wide data lines only after bus width command
// - Detect pull-up enabled at power-up
// - Detect pad level selects native or SPI mode
// - Detect pull-up command disconnects the pull-up
// - I/O mode interrupt on idle data line one
// - I/O mode data line two as read wait
// - Relative address unused in SPI mode
// - Card proposes 16-bit address, host confirms
// - Card provides the information register set
// - Power-on detection gives defined state
// - Power cycle or reset command resets card
// - Data lines zero, one carry reference clock
// - Lane directions follow duplex setting
// - Unused legacy lines undriven in lane mode
// - Lane-mode I/O interrupt on data line two
// - Unused lines low before supply off
package card_pad_pkg;
	localparam logic [7:0]  REG_CTRL      = 8'h00;
	localparam logic [7:0]  REG_STATUS    = 8'h04;
	localparam logic [7:0]  REG_ADDR      = 8'h08;
	localparam logic [7:0]  REG_DRIVER    = 8'h0C;
	localparam logic [7:0]  REG_OPCOND    = 8'h10;
	localparam logic [7:0]  REG_CARDSTAT  = 8'h14;
	localparam logic [7:0]  REG_CMD       = 8'h18;
	localparam logic [7:0]  REG_IDENT     = 8'h20;
	localparam logic [7:0]  REG_SPECIFIC  = 8'h30;
	localparam logic [7:0]  REG_CONFIG    = 8'h40;
	localparam logic [7:0]  REG_EXTSTAT   = 8'h80;
	localparam logic [7:0]  REG_EXT_END   = 8'hBC;
	// Control fields
	localparam int CTRL_IO_MODE  = 0;
	localparam int CTRL_LANE     = 1;
	localparam int CTRL_HALF     = 2;
	localparam int CTRL_HIBER    = 3;
	localparam int CTRL_IRQ      = 4;
	localparam int CTRL_RDWAIT   = 5;
	localparam int CTRL_XFER     = 6;
	// Command register codes
	localparam logic [2:0] CMD_RESET      = 3'h1;
	localparam logic [2:0] CMD_WIDE       = 3'h2;
	localparam logic [2:0] CMD_NARROW     = 3'h3;
	localparam logic [2:0] CMD_PULLUP_OFF = 3'h4;
	localparam logic [2:0] CMD_PULLUP_ON  = 3'h5;
	localparam logic [2:0] CMD_CONFIRM    = 3'h6;
	// Reset values
	localparam logic [15:0] ADDR_PROPOSED  = 16'h0001;
	localparam logic [15:0] DRIVER_RESET   = 16'h0404;
	localparam logic [31:0] OPCOND_RESET   = 32'h00FF8000;
	localparam logic [31:0] CARDSTAT_RESET = 32'h00000000;
	localparam logic [6:0]  CTRL_RESET     = 7'h00;
	// AHB codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	typedef enum logic [2:0]
	{
		MODE_UNSET  = 3'b001,
		MODE_NATIVE = 3'b010,
		MODE_SPI    = 3'b100
	} bus_mode_e;

	typedef struct packed
	{
		logic [3:0] dataIn;
		logic       cmdIn;
		logic       clkIn;
	} legacy_in_s;

	typedef struct packed
	{
		logic [3:0] dataOut;
		logic [3:0] dataOe;
		logic       cmdOut;
		logic       cmdOe;
		logic       detectPullup;
	} legacy_out_s;

	typedef struct packed
	{
		logic downstreamOe;
		logic upstreamOe;
		logic refClkSel;
	} lane_ctrl_s;
endpackage : card_pad_pkg

/* rtl/card_pad_mode_and_line_control.sv */
// Pad mode selection, line direction control and register file of the card
`timescale 1ns/1ps
module card_pad_mode_and_line_control
(
	// Clock, reset, enable
	input  wire logic                       clk_sys,
	input  wire logic                       rst,
	input  wire logic                       clkEn,
	// AHB-Lite slave
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic      [31:0]                hrdata,
	output logic                            hreadyout,
	output logic                            hresp,
	// Legacy pads
	input  wire card_pad_pkg::legacy_in_s   padIn,
	output card_pad_pkg::legacy_out_s       padOut,
	// Lane pads
	output card_pad_pkg::lane_ctrl_s        laneCtrl,
	// Mode and supply status
	output logic                            spiMode,
	output logic                            hibernateReady
);
	import card_pad_pkg::*;

	// Pin synchronisers
	logic [5:0] syncA_r;
	logic [5:0] syncB_r;
	logic [5:0] syncA_nxt;
	logic [5:0] syncB_nxt;
	logic       clkPrev_r;
	logic       clkPrev_nxt;
	legacy_in_s padSync;

	always_comb
	begin
		syncA_nxt = clkEn ? padIn : syncA_r;
		syncB_nxt = clkEn ? syncA_r : syncB_r;
		clkPrev_nxt = clkEn ? syncB_r[0] : clkPrev_r;
		padSync = syncB_r;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			// Idle pad levels: clock low, others high, so no false edge follows reset
			syncA_r <= 6'h3E;
			syncB_r <= 6'h3E;
			clkPrev_r <= 1'b0;
		end
		else
		begin
			syncA_r <= syncA_nxt;
			syncB_r <= syncB_nxt;
			clkPrev_r <= clkPrev_nxt;
		end
	end

	logic linkClkRise;
	assign linkClkRise = padSync.clkIn & ~clkPrev_r;

	// Register file and mode state
	bus_mode_e   mode_r;
	bus_mode_e   mode_nxt;
	logic        wide_r;
	logic        wide_nxt;
	logic        pullup_r;
	logic        pullup_nxt;
	logic        addrValid_r;
	logic        addrValid_nxt;
	logic [6:0]  ctrl_r;
	logic [6:0]  ctrl_nxt;
	logic [15:0] addr_r;
	logic [15:0] addr_nxt;
	logic [15:0] driver_r;
	logic [15:0] driver_nxt;
	logic [15:0] linkEdges_r;
	logic [15:0] linkEdges_nxt;

	logic [127:0] identVal;
	logic [127:0] specificVal;
	logic [63:0]  configVal;
	logic [511:0] extStatVal;
	assign identVal    = {8{16'h0F0F}};
	assign specificVal = {8{16'h4000}};
	assign configVal   = 64'h0000000002350000;
	assign extStatVal  = '0;

	// AHB address phase capture
	logic        wrPend_r;
	logic        wrPend_nxt;
	logic [7:0]  wrAddr_r;
	logic [7:0]  wrAddr_nxt;
	logic [31:0] rdData_r;
	logic [31:0] rdData_nxt;
	logic        access;

	assign access = hsel & hready & (htrans == HTRANS_NONSEQ) & (hsize == HSIZE_WORD);

	function automatic logic [31:0] readWord(input logic [7:0] a,
		input logic [31:0] statusWord, input logic [31:0] ctrlWord,
		input logic [15:0] addrWord, input logic [127:0] ident,
		input logic [127:0] spec, input logic [63:0] conf, input logic [511:0] ext);
		logic [31:0] r;
		r = 32'h00000000;
		if (a == REG_CTRL)
			r = ctrlWord;
		else if (a == REG_STATUS)
			r = statusWord;
		else if (a == REG_ADDR)
			r = {16'h0000, addrWord};
		else if (a == REG_OPCOND)
			r = OPCOND_RESET;
		else if (a == REG_CARDSTAT)
			r = CARDSTAT_RESET;
		else if (a >= REG_IDENT && a < REG_SPECIFIC)
			r = ident[a[3:2]*32 +: 32];
		else if (a >= REG_SPECIFIC && a < REG_CONFIG)
			r = spec[a[3:2]*32 +: 32];
		else if (a == REG_CONFIG || a == 8'h44)
			r = conf[a[2]*32 +: 32];
		else if (a >= REG_EXTSTAT && a <= REG_EXT_END)
			r = ext[a[5:2]*32 +: 32];
		return r;
	endfunction : readWord

	logic [31:0] statusWord;
	logic [15:0] addrShown;
	always_comb
	begin
		addrShown = (mode_r == MODE_SPI) ? 16'h0000 : addr_r;
		statusWord = {linkEdges_r, 8'h00, 1'b0, addrValid_r, pullup_r, wide_r,
			mode_r == MODE_SPI, mode_r == MODE_NATIVE, padSync.dataIn[3], padSync.clkIn};
	end

	always_comb
	begin
		mode_nxt      = mode_r;
		wide_nxt      = wide_r;
		pullup_nxt    = pullup_r;
		addrValid_nxt = addrValid_r;
		ctrl_nxt      = ctrl_r;
		addr_nxt      = addr_r;
		driver_nxt    = driver_r;
		linkEdges_nxt = linkEdges_r + {15'h0000, linkClkRise};
		wrPend_nxt    = access & hwrite;
		wrAddr_nxt    = haddr[7:0];
		rdData_nxt    = rdData_r;
		if (access && !hwrite)
			rdData_nxt = readWord(haddr[7:0], statusWord, {25'h0, ctrl_r}, addrShown,
				identVal, specificVal, configVal, extStatVal);
		if (wrPend_r)
		begin
			if (wrAddr_r == REG_CTRL)
				ctrl_nxt = hwdata[6:0];
			else if (wrAddr_r == REG_DRIVER)
				driver_nxt = hwdata[15:0];
			else if (wrAddr_r == REG_CMD)
			begin
				unique case (hwdata[2:0])
					CMD_RESET:
					begin
						wide_nxt = 1'b0;
						addrValid_nxt = 1'b0;
						addr_nxt = ADDR_PROPOSED;
						if (mode_r == MODE_UNSET)
							mode_nxt = padSync.dataIn[3] ? MODE_NATIVE : MODE_SPI;
					end
					CMD_WIDE:
						wide_nxt = (mode_r == MODE_NATIVE);
					CMD_NARROW:
						wide_nxt = 1'b0;
					CMD_PULLUP_OFF:
						pullup_nxt = 1'b0;
					CMD_PULLUP_ON:
						pullup_nxt = 1'b1;
					CMD_CONFIRM:
						addrValid_nxt = (mode_r == MODE_NATIVE);
					default:
						mode_nxt = mode_r;
				endcase
			end
		end
		if (!clkEn)
		begin
			mode_nxt      = mode_r;
			wide_nxt      = wide_r;
			pullup_nxt    = pullup_r;
			addrValid_nxt = addrValid_r;
			ctrl_nxt      = ctrl_r;
			addr_nxt      = addr_r;
			driver_nxt    = driver_r;
			linkEdges_nxt = linkEdges_r;
			wrPend_nxt    = wrPend_r;
			wrAddr_nxt    = wrAddr_r;
			rdData_nxt    = rdData_r;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			mode_r      <= MODE_UNSET;
			wide_r      <= 1'b0;
			pullup_r    <= 1'b1;
			addrValid_r <= 1'b0;
			ctrl_r      <= CTRL_RESET;
			addr_r      <= ADDR_PROPOSED;
			driver_r    <= DRIVER_RESET;
			linkEdges_r <= 16'h0000;
			wrPend_r    <= 1'b0;
			wrAddr_r    <= 8'h00;
			rdData_r    <= 32'h00000000;
		end
		else
		begin
			mode_r      <= mode_nxt;
			wide_r      <= wide_nxt;
			pullup_r    <= pullup_nxt;
			addrValid_r <= addrValid_nxt;
			ctrl_r      <= ctrl_nxt;
			addr_r      <= addr_nxt;
			driver_r    <= driver_nxt;
			linkEdges_r <= linkEdges_nxt;
			wrPend_r    <= wrPend_nxt;
			wrAddr_r    <= wrAddr_nxt;
			rdData_r    <= rdData_nxt;
		end
	end

	assign hrdata    = rdData_r;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Pad direction logic
	legacy_out_s padOut_nxt;
	legacy_out_s padOut_r;
	lane_ctrl_s  lane_nxt;
	lane_ctrl_s  lane_r;
	logic        lane;
	logic        ioMode;

	always_comb
	begin
		lane = ctrl_r[CTRL_LANE];
		ioMode = ctrl_r[CTRL_IO_MODE];
		padOut_nxt = '0;
		lane_nxt = '0;
		padOut_nxt.detectPullup = pullup_r & ~lane;
		if (lane)
		begin
			lane_nxt.refClkSel = 1'b1;
			lane_nxt.downstreamOe = ctrl_r[CTRL_HALF] & ctrl_r[CTRL_XFER];
			lane_nxt.upstreamOe = ~ctrl_r[CTRL_HALF] | ~ctrl_r[CTRL_XFER];
			if (ioMode && !ctrl_r[CTRL_HIBER])
			begin
				padOut_nxt.dataOe[2] = 1'b1;
				padOut_nxt.dataOut[2] = ~ctrl_r[CTRL_IRQ];
			end
		end
		else if (!ctrl_r[CTRL_HIBER])
		begin
			lane_nxt.upstreamOe = 1'b1;
			if (ioMode && mode_r == MODE_NATIVE && !(wide_r && ctrl_r[CTRL_XFER]))
			begin
				padOut_nxt.dataOe[1] = 1'b1;
				padOut_nxt.dataOut[1] = ~ctrl_r[CTRL_IRQ];
			end
			if (ioMode && wide_r && ctrl_r[CTRL_RDWAIT])
			begin
				padOut_nxt.dataOe[2] = 1'b1;
				padOut_nxt.dataOut[2] = 1'b0;
			end
		end
		if (!clkEn)
		begin
			padOut_nxt = padOut_r;
			lane_nxt = lane_r;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			padOut_r <= '{dataOut: 4'h0, dataOe: 4'h0, cmdOut: 1'b0, cmdOe: 1'b0,
				detectPullup: 1'b1};
			lane_r   <= '0;
		end
		else
		begin
			padOut_r <= padOut_nxt;
			lane_r   <= lane_nxt;
		end
	end

	assign padOut   = padOut_r;
	assign laneCtrl = lane_r;
	assign spiMode  = (mode_r == MODE_SPI);
	assign hibernateReady = ctrl_r[CTRL_HIBER] & ~|padOut_r.dataOe & ~padOut_r.detectPullup;
endmodule : card_pad_mode_and_line_control

/* test/card_pad_sva.sv */
// Assertions on the ports of the card pad mode and line control block
`timescale 1ns/1ps
module card_pad_sva
(
	// Clock, reset, enable
	input wire logic                        clk_sys,
	input wire logic                        rst,
	input wire logic                        clkEn,
	// Bus
	input wire logic                        hsel,
	input wire logic [31:0]                 haddr,
	input wire logic [1:0]                  htrans,
	input wire logic                        hwrite,
	input wire logic [2:0]                  hsize,
	input wire logic [31:0]                 hwdata,
	input wire logic                        hready,
	input wire logic [31:0]                 hrdata,
	// Pads and status
	input wire card_pad_pkg::legacy_out_s   padOut,
	input wire card_pad_pkg::lane_ctrl_s    laneCtrl,
	input wire logic                        spiMode,
	input wire logic                        hibernateReady
);
	import card_pad_pkg::*;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic cmdPend;
	logic wideSeen;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			cmdPend <= 1'b0;
			wideSeen <= 1'b0;
		end
		else if (clkEn)
		begin
			cmdPend <= hsel && hready && hwrite && htrans == HTRANS_NONSEQ
				&& hsize == HSIZE_WORD && haddr[7:0] == REG_CMD;
			if (cmdPend && hwdata[2:0] == CMD_WIDE)
				wideSeen <= 1'b1;
		end
	end
	a_reset_pads:
	assert property ($fell(rst) |-> padOut.detectPullup && padOut.dataOe == 4'h0)
		else $error("pads wrong after reset");
	a_wide_gate:
	assert property (padOut.dataOe[3] || (padOut.dataOe[2] && !laneCtrl.refClkSel) |-> wideSeen)
		else $error("data three driven before wide command");
	a_spi_select_in:
	assert property (spiMode |-> !padOut.dataOe[3])
		else $error("select pad driven in serial mode");
	a_spi_no_addr:
	assert property (clkEn && spiMode && hsel && hready && !hwrite && htrans == HTRANS_NONSEQ
		&& hsize == HSIZE_WORD && haddr[7:0] == REG_ADDR |=> hrdata == 32'h0)
		else $error("address readable in serial mode");
	a_lane_refclk:
	assert property (laneCtrl.refClkSel |-> padOut.dataOe[1:0] == 2'h0)
		else $error("clock pads driven in lane mode");
	a_lane_undriven:
	assert property (laneCtrl.refClkSel |-> !padOut.cmdOe && !padOut.dataOe[3])
		else $error("unused line driven in lane mode");
	a_mode_kept:
	assert property ($past(spiMode) && !$past(rst) |-> spiMode)
		else $error("latched mode changed");
	a_pullup_drop:
	assert property (cmdPend && clkEn && hwdata[2:0] == CMD_PULLUP_OFF
		|-> ##[1:3] !padOut.detectPullup)
		else $error("pull-up kept after command");
	a_hiber_safe:
	assert property (hibernateReady |-> padOut.dataOe == 4'h0 && padOut.dataOut == 4'h0
		&& !padOut.cmdOe && !padOut.detectPullup)
		else $error("lines active at hibernate");
endmodule : card_pad_sva
bind card_pad_mode_and_line_control card_pad_sva u_sva (.clk_sys, .rst, .clkEn, .hsel,
	.haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .padOut, .laneCtrl,
	.spiMode, .hibernateReady);

/* test/card_host_model.sv */
// Host side model driving the card clock, command and data pads
`timescale 1ns/1ps
module card_host_model
(
	// Clock
	input  wire logic                       clk_sys,
	// Bench control
	input  wire logic                       frameOn,
	input  wire logic                       detDrive,
	input  wire logic                       detLvl,
	input  wire logic                       laneMode,
	// Card pads
	input  wire card_pad_pkg::legacy_out_s  padOut,
	output card_pad_pkg::legacy_in_s        padIn
);
	import card_pad_pkg::*;
	logic linkClk = 1'b0;
	logic tg = 1'b0;
	always #400 linkClk = frameOn ? ~linkClk : 1'b0;
	always @(posedge clk_sys) tg <= ~tg;
	always_comb
	begin
		padIn.clkIn = linkClk & ~laneMode;
		padIn.cmdIn = laneMode ? 1'b0 : tg;
		for (int i = 0; i < 3; i++)
			padIn.dataIn[i] = padOut.dataOe[i] ? padOut.dataOut[i]
				: (laneMode ? 1'b0 : ((i == 0) ? tg : 1'b1));
		if (detDrive)
			padIn.dataIn[3] = detLvl;
		else if (padOut.dataOe[3])
			padIn.dataIn[3] = padOut.dataOut[3];
		else if (padOut.detectPullup)
			padIn.dataIn[3] = 1'b1;
		else
			padIn.dataIn[3] = laneMode ? 1'b0 : tg;
	end
endmodule : card_host_model

/* test/card_pad_mode_and_line_control_tb_top.sv */
// Testbench for the card pad mode and line control block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module card_pad_mode_and_line_control_tb_top;
	import card_pad_pkg::*;
	logic        clk_sys = 0, rst = 1, clkEn = 1, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, s1;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = HSIZE_WORD;
	logic        hreadyout, hresp, spiMode, hibernateReady;
	logic        frameOn = 0, detDrive = 0, detLvl = 0, laneMode = 0;
	logic [7:0]  a;
	legacy_in_s  padIn;
	legacy_out_s padOut;
	lane_ctrl_s  laneCtrl;
	int          err_count = 0, n_tests = 0, cyc = 0;
	always #50 clk_sys = ~clk_sys;
	card_pad_mode_and_line_control DUT (.clk_sys, .rst, .clkEn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .padIn,
		.padOut, .laneCtrl, .spiMode, .hibernateReady);
	card_host_model u_host (.clk_sys, .frameOn, .detDrive, .detLvl, .laneMode, .padOut, .padIn);
	task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, ad};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#10;
	endtask : settle
	task automatic cmd(input logic [2:0] c);
		ahb(1'b1, REG_CMD, {29'h0, c});
		settle();
	endtask : cmd
	task automatic ctrl(input logic [31:0] v);
		ahb(1'b1, REG_CTRL, v);
		settle();
	endtask : ctrl
	task automatic reset_dut();
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		settle();
	endtask : reset_dut
	task automatic stop_test();
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_count++;
			stop_test();
		end
	end
	initial
	begin
		void'($urandom(70));
		reset_dut();
		`CHK("oe", 4'h0, padOut.dataOe)
		`CHK("pull", 1'b1, padOut.detectPullup)
		`CHK("spi", 1'b0, spiMode)
		ahb(1'b0, REG_OPCOND, 32'h0);
		`CHK("opc", OPCOND_RESET, rd)
		`CHK("resp", 1'b0, hresp)
		ahb(1'b0, REG_CARDSTAT, 32'h0);
		`CHK("cst", CARDSTAT_RESET, rd)
		for (int i = 0; i < 4; i++)
		begin
			a = 8'hC0 + 8'($urandom_range(15)) * 8'h04;
			ahb(1'b1, a, $urandom);
			ahb(1'b0, a, 32'h0);
			`CHK("unmap", 32'h0, rd)
		end
		cmd(CMD_RESET);
		ahb(1'b0, REG_STATUS, 32'h0);
		`CHK("native", 1'b1, rd[2])
		`CHK("detect", 1'b1, rd[1])
		s1 = rd;
		ahb(1'b1, REG_ADDR, $urandom);
		ahb(1'b0, REG_ADDR, 32'h0);
		`CHK("addr", {16'h0, ADDR_PROPOSED}, rd)
		`CHK("narrow", 3'h0, padOut.dataOe[3:1])
		frameOn = 1'b1;
		repeat (40) @(posedge clk_sys);
		frameOn = 1'b0;
		ahb(1'b0, REG_STATUS, 32'h0);
		`CHK("edges", 1'b1, rd[31:16] !== s1[31:16])
		cmd(CMD_WIDE);
		ahb(1'b0, REG_STATUS, 32'h0);
		`CHK("wide", 1'b1, rd[4])
		cmd(CMD_CONFIRM);
		ahb(1'b0, REG_STATUS, 32'h0);
		`CHK("conf", 1'b1, rd[6])
		ctrl(32'h40);
		ctrl(32'h11);
		`CHK("irq", 2'h2, {padOut.dataOe[1], padOut.dataOut[1]})
		ctrl(32'h51);
		`CHK("irqx", 1'b0, padOut.dataOe[1])
		ctrl(32'h21);
		`CHK("rdw", 2'h2, {padOut.dataOe[2], padOut.dataOut[2]})
		ctrl(32'h0);
		cmd(CMD_PULLUP_OFF);
		`CHK("poff", 1'b0, padOut.detectPullup)
		cmd(CMD_PULLUP_ON);
		`CHK("pon", 1'b1, padOut.detectPullup)
		detDrive = 1'b1;
		cmd(CMD_RESET);
		`CHK("kept", 1'b0, spiMode)
		ahb(1'b0, REG_STATUS, 32'h0);
		`CHK("rstwide", 1'b0, rd[4])
		`CHK("rstconf", 1'b0, rd[6])
		reset_dut();
		cmd(CMD_RESET);
		`CHK("spisel", 1'b1, spiMode)
		ahb(1'b0, REG_ADDR, 32'h0);
		`CHK("spiaddr", 32'h0, rd)
		cmd(CMD_WIDE);
		ahb(1'b0, REG_STATUS, 32'h0);
		`CHK("spiwide", 1'b0, rd[4])
		detDrive = 1'b0;
		reset_dut();
		laneMode = 1'b1;
		ctrl(32'h02);
		`CHK("ref", 1'b1, laneCtrl.refClkSel)
		`CHK("dirs", 2'h1, {laneCtrl.downstreamOe, laneCtrl.upstreamOe})
		`CHK("unused", 2'h0, {padOut.cmdOe, padOut.dataOe[3]})
		ctrl(32'h46);
		`CHK("hdx", 2'h2, {laneCtrl.downstreamOe, laneCtrl.upstreamOe})
		ctrl(32'h13);
		`CHK("lirq", 2'h2, {padOut.dataOe[2], padOut.dataOut[2]})
		ctrl(32'h0A);
		cmd(CMD_PULLUP_OFF);
		`CHK("hib", 1'b1, hibernateReady)
		@(posedge clk_sys);
		clkEn <= 1'b0;
		ctrl(32'h0);
		@(posedge clk_sys);
		clkEn <= 1'b1;
		settle();
		`CHK("frozen", 1'b1, hibernateReady)
		stop_test();
	end
endmodule : card_pad_mode_and_line_control_tb_top
